/* File: cidrx_defines.vh */
// constants for the caller-identity receiver control block
`ifndef CIDRX_DEFINES_VH
`define CIDRX_DEFINES_VH

// ----------------------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------------------
`define CIDRX_CLK_HZ          25000000
`define CIDRX_BAUD_RATE       1200
// bit period in cycles: clock rate over baud rate, rounded down
`define CIDRX_BIT_CYCLES      16'h5161

// ----------------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define CIDRX_CTRL_OFS        12'h000
`define CIDRX_STATUS_OFS      12'h004
`define CIDRX_INT_ENABLE_OFS  12'h008
`define CIDRX_INT_CLEAR_OFS   12'h00C
`define CIDRX_STATE_OFS       12'h010

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define CIDRX_CTRL_RST        1'h1
`define CIDRX_INT_ENABLE_RST  5'h00
// synchroniser levels in reset: rc node and fsk bit idle high
`define CIDRX_SYNC_RST        9'h030

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define CIDRX_CTRL_DEMOD_GATE 0
`define CIDRX_EV_WORD         0
`define CIDRX_EV_LINE         1
`define CIDRX_EV_CARRIER      2
`define CIDRX_EV_OVERRUN      3
`define CIDRX_EV_ALERT        4
`define CIDRX_EV_WIDTH        5
`define CIDRX_ST_WORD_LSB     8

`endif

/* File: cidrx_ctrl.v */
// caller-identity receiver control: interface modes, power-down, demod, trigger
//
// Operation
// - low selects mode 0, high mode 1
// - data clock output in mode 0 only
// - power-down leaves only trigger path alive
// - demodulate only while demod enable is high
// - RC node times trigger low to output high
// - trigger output flags reversal or ringing
// - demodulate caller data at 1200 baud
// - run from the reference clock input
// - mode 1 shifts bits on host clock rise
// - mode 0 word ready low after eighth pulse
// - interrupt low while trigger, ready or alert active
// - carrier output low while in-band signal present
//
// The address map and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`include "cidrx_defines.vh"

module cidrx_ctrl #(
    parameter [15:0] BIT_CYCLES = `CIDRX_BIT_CYCLES
) (
    input  wire        ref_clk,
    input  wire        sys_rst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    output wire        irq,
    input  wire        interface_mode,
    input  wire        power_down_request,
    input  wire        demod_enable,
    input  wire        fsk_bit_in,
    input  wire        carrier_in,
    input  wire        alert_tone_in,
    input  wire        line_event_input,
    input  wire        event_rc_timing_in,
    output wire        event_rc_timing_out,
    output wire        event_rc_timing_oe,
    output reg         line_event_detected,
    input  wire        serial_data_clock_in,
    output wire        serial_data_clock_out,
    output wire        serial_data_clock_oe,
    output reg         serial_data,
    output wire        word_ready_n,
    output reg         carrier_present_n,
    output reg         alert_tone_qualified,
    output wire        interrupt_out,
    output wire        interrupt_oe
);

    // ------------------------------------------------------------------------
    // constants
    // ------------------------------------------------------------------------
    localparam [15:0] HALF_BIT = {1'b0, BIT_CYCLES[15:1]};
    localparam [1:0]  RX_IDLE  = 2'h0;
    localparam [1:0]  RX_START = 2'h1;
    localparam [1:0]  RX_DATA  = 2'h2;
    localparam [1:0]  RX_STOP  = 2'h3;
    localparam        NSYNC    = 9;
    localparam [8:0]  SYNC_RST = `CIDRX_SYNC_RST;

    // ------------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------------
    // reference clock domain: every pin is sampled on ref_clk
    wire [NSYNC-1:0] raw_in;
    wire [NSYNC-1:0] sync_in;
    assign raw_in = {serial_data_clock_in, alert_tone_in, carrier_in, fsk_bit_in,
                     event_rc_timing_in, line_event_input, demod_enable,
                     power_down_request, interface_mode};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
            reg meta_reg;
            reg stab_reg;
            always @(posedge ref_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    meta_reg <= SYNC_RST[gi];
                    stab_reg <= SYNC_RST[gi];
                end else begin
                    meta_reg <= raw_in[gi];
                    stab_reg <= meta_reg;
                end
            end
            assign sync_in[gi] = stab_reg;
        end
    endgenerate

    wire mode1_s    = sync_in[0];
    wire pd_s       = sync_in[1];
    wire en_s       = sync_in[2];
    wire line_s     = sync_in[3];
    wire rc_s       = sync_in[4];
    wire fsk_s      = sync_in[5];
    wire carrier_s  = sync_in[6];
    wire alert_s    = sync_in[7];
    wire hclk_s     = sync_in[8];

    reg  [0:0]               ctrl_reg;
    reg  [`CIDRX_EV_WIDTH-1:0] status_reg;
    reg  [`CIDRX_EV_WIDTH-1:0] int_enable_reg;

    wire active = ~pd_s;
    wire demod_on = active & en_s & ctrl_reg[`CIDRX_CTRL_DEMOD_GATE];

    // ------------------------------------------------------------------------
    // line event trigger (alive in power-down)
    // ------------------------------------------------------------------------
    // discharge rc node while trigger input is high
    assign event_rc_timing_out = 1'b0;
    assign event_rc_timing_oe  = line_s;

    reg line_event_prev_reg;
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            line_event_detected <= 1'b1;
            line_event_prev_reg <= 1'b1;
        end else begin
            line_event_detected <= rc_s;
            line_event_prev_reg <= line_event_detected;
        end
    end
    wire line_event_fall = line_event_prev_reg & ~line_event_detected;

    // ------------------------------------------------------------------------
    // carrier and alert outputs
    // ------------------------------------------------------------------------
    reg alert_prev_reg;
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            carrier_present_n    <= 1'b1;
            alert_tone_qualified <= 1'b0;
            alert_prev_reg       <= 1'b0;
        end else begin
            carrier_present_n    <= ~(carrier_s & active);
            alert_tone_qualified <= alert_s & active;
            alert_prev_reg       <= alert_tone_qualified;
        end
    end
    wire carrier_onset = carrier_present_n & carrier_s & active;
    wire alert_rise    = ~alert_prev_reg & alert_tone_qualified;

    // ------------------------------------------------------------------------
    // 1200 baud bit receiver
    // ------------------------------------------------------------------------
    reg  [1:0]  rx_state_reg;
    reg  [15:0] rx_cnt_reg;
    reg  [2:0]  rx_idx_reg;
    reg  [7:0]  rx_shift_reg;
    reg  [7:0]  rx_word_reg;
    reg  [15:0] serial_data_clock_cnt_reg;
    reg  [15:0] ready0_cnt_reg;
    reg  [7:0]  tx_shift_reg;
    reg  [3:0]  tx_count_reg;
    reg         hclk_prev_reg;
    reg         word_event;
    reg         overrun_event;
    wire        rx_tick   = (rx_cnt_reg == 16'h0000);
    wire        hclk_rise = hclk_s & ~hclk_prev_reg;
    wire        tx_valid  = (tx_count_reg != 4'h0);

    // framed receive at the bit period
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_state_reg <= RX_IDLE;
            rx_cnt_reg   <= 16'h0000;
            rx_idx_reg   <= 3'h0;
            rx_shift_reg <= 8'h00;
            rx_word_reg  <= 8'h00;
        end else if (!demod_on) begin
            rx_state_reg <= RX_IDLE;
            rx_cnt_reg   <= 16'h0000;
            rx_idx_reg   <= 3'h0;
        end else begin
            if (!rx_tick) begin
                rx_cnt_reg <= rx_cnt_reg - 16'h0001;
            end
            case (rx_state_reg)
                RX_IDLE: begin
                    if (!fsk_s) begin
                        rx_state_reg <= RX_START;
                        rx_cnt_reg   <= HALF_BIT;
                    end
                end
                RX_START: begin
                    if (rx_tick) begin
                        rx_state_reg <= fsk_s ? RX_IDLE : RX_DATA;
                        // the tick cycle counts as one, so reload one short
                        rx_cnt_reg   <= BIT_CYCLES - 16'h0001;
                        rx_idx_reg   <= 3'h0;
                    end
                end
                RX_DATA: begin
                    if (rx_tick) begin
                        rx_shift_reg <= {fsk_s, rx_shift_reg[7:1]};
                        rx_cnt_reg   <= BIT_CYCLES - 16'h0001;
                        rx_idx_reg   <= rx_idx_reg + 3'h1;
                        if (rx_idx_reg == 3'h7) begin
                            rx_state_reg <= RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    if (rx_tick) begin
                        rx_state_reg <= RX_IDLE;
                        if (fsk_s) begin
                            rx_word_reg <= rx_shift_reg;
                        end
                    end
                end
                default: begin
                    rx_state_reg <= RX_IDLE;
                end
            endcase
        end
    end

    wire bit_sample = demod_on & rx_tick & (rx_state_reg == RX_DATA);
    wire word_done  = demod_on & rx_tick & (rx_state_reg == RX_STOP) & fsk_s;

    // ------------------------------------------------------------------------
    // three-wire serial interface
    // ------------------------------------------------------------------------
    always @* begin
        word_event    = word_done;
        overrun_event = word_done & mode1_s & tx_valid;
    end

    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            serial_data    <= 1'b1;
            serial_data_clock_cnt_reg   <= 16'h0000;
            ready0_cnt_reg <= 16'h0000;
            tx_shift_reg   <= 8'h00;
            tx_count_reg   <= 4'h0;
            hclk_prev_reg  <= 1'b0;
        end else begin
            hclk_prev_reg <= hclk_s;
            if (serial_data_clock_cnt_reg != 16'h0000) begin
                serial_data_clock_cnt_reg <= serial_data_clock_cnt_reg - 16'h0001;
            end
            if (ready0_cnt_reg != 16'h0000) begin
                ready0_cnt_reg <= ready0_cnt_reg - 16'h0001;
            end
            if (!active) begin
                serial_data_clock_cnt_reg   <= 16'h0000;
                ready0_cnt_reg <= 16'h0000;
                tx_count_reg   <= 4'h0;
            end else if (!mode1_s) begin
                tx_count_reg <= 4'h0;
                if (bit_sample) begin
                    serial_data <= fsk_s;
                    serial_data_clock_cnt_reg <= HALF_BIT + 16'h0001;
                end
                if (word_done) begin
                    ready0_cnt_reg <= HALF_BIT;
                end
            end else begin
                serial_data_clock_cnt_reg   <= 16'h0000;
                ready0_cnt_reg <= 16'h0000;
                if (word_done) begin
                    tx_shift_reg <= rx_shift_reg;
                    tx_count_reg <= 4'h8;
                end else if (hclk_rise && tx_valid) begin
                    // shift out on host clock rise
                    serial_data  <= tx_shift_reg[0];
                    tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
                    tx_count_reg <= tx_count_reg - 4'h1;
                end
            end
        end
    end

    assign serial_data_clock_oe  = active & ~mode1_s;
    assign serial_data_clock_out = (serial_data_clock_cnt_reg != 16'h0000) && (serial_data_clock_cnt_reg <= HALF_BIT);
    assign word_ready_n = mode1_s ? ~tx_valid : (ready0_cnt_reg == 16'h0000);

    assign interrupt_out = 1'b0;
    assign interrupt_oe  = ~line_event_detected | ~word_ready_n | alert_tone_qualified;

    // ------------------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------------------
    wire apb_setup  = psel & ~penable;
    wire apb_access = psel & penable;
    wire addr_hit   = (paddr == `CIDRX_CTRL_OFS) | (paddr == `CIDRX_STATUS_OFS) |
                      (paddr == `CIDRX_INT_ENABLE_OFS) | (paddr == `CIDRX_INT_CLEAR_OFS) |
                      (paddr == `CIDRX_STATE_OFS);
    wire wr_en      = apb_access & pwrite & addr_hit;

    assign pready  = 1'b1;
    assign pslverr = apb_access & ~addr_hit;

    wire [`CIDRX_EV_WIDTH-1:0] ev_set;
    assign ev_set = {alert_rise, overrun_event, carrier_onset, line_event_fall, word_event};

    wire [`CIDRX_EV_WIDTH-1:0] ev_clr;
    assign ev_clr = (wr_en && paddr == `CIDRX_INT_CLEAR_OFS) ?
                    pwdata[`CIDRX_EV_WIDTH-1:0] : {`CIDRX_EV_WIDTH{1'b0}};

    wire [31:0] state_word;
    assign state_word = {16'h0000, rx_word_reg, tx_valid, word_ready_n,
                         alert_tone_qualified, ~carrier_present_n, line_event_detected,
                         demod_on, pd_s, mode1_s};

    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_reg       <= `CIDRX_CTRL_RST;
            int_enable_reg <= `CIDRX_INT_ENABLE_RST;
            status_reg     <= {`CIDRX_EV_WIDTH{1'b0}};
            prdata         <= 32'h00000000;
        end else begin
            // set wins over a simultaneous clear
            status_reg <= (status_reg & ~ev_clr) | ev_set;
            if (wr_en && paddr == `CIDRX_CTRL_OFS) begin
                ctrl_reg <= pwdata[0];
            end
            if (wr_en && paddr == `CIDRX_INT_ENABLE_OFS) begin
                int_enable_reg <= pwdata[`CIDRX_EV_WIDTH-1:0];
            end
            if (apb_setup && !pwrite) begin
                case (paddr)
                    `CIDRX_CTRL_OFS:       prdata <= {31'h00000000, ctrl_reg};
                    `CIDRX_STATUS_OFS:     prdata <= {27'h0000000, status_reg};
                    `CIDRX_INT_ENABLE_OFS: prdata <= {27'h0000000, int_enable_reg};
                    `CIDRX_STATE_OFS:      prdata <= state_word;
                    default:               prdata <= 32'h00000000;
                endcase
            end
        end
    end

    assign irq = |(status_reg & int_enable_reg);

endmodule // cidrx_ctrl

/* File: cidrx_ctrl_asserts.sv */
// concurrent checks on the caller-identity receiver control ports
`timescale 1ns/1ps
module cidrx_ctrl_asserts (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic interface_mode,
    input wire logic power_down_request,
    input wire logic demod_enable,
    input wire logic carrier_in,
    input wire logic line_event_input,
    input wire logic event_rc_timing_in,
    input wire logic event_rc_timing_oe,
    input wire logic line_event_detected,
    input wire logic serial_data_clock_out,
    input wire logic serial_data_clock_oe,
    input wire logic serial_data,
    input wire logic word_ready_n,
    input wire logic carrier_present_n,
    input wire logic alert_tone_qualified,
    input wire logic interrupt_oe
);
    default clocking cidrx_cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    // pins settle through a two-flop synchroniser
    sequence s_trig_high;
        line_event_input[*4];
    endsequence
    sequence s_node_low;
        (!event_rc_timing_in)[*4];
    endsequence
    sequence s_int_idle;
        (line_event_detected && word_ready_n && !alert_tone_qualified)[*2];
    endsequence

    mode1_clk_in_a: assert property (interface_mode[*4] |-> !serial_data_clock_oe)
        else $error("data clock driven in mode 1");
    mode0_clk_out_a: assert property (
        (!interface_mode && !power_down_request)[*4] |-> serial_data_clock_oe)
        else $error("data clock not driven in mode 0");
    pd_quiet_a: assert property (
        power_down_request[*4] |-> !serial_data_clock_oe && carrier_present_n)
        else $error("outputs active in power-down");
    trig_discharge_a: assert property (s_trig_high |-> event_rc_timing_oe)
        else $error("timing node not discharged");
    trig_release_a: assert property ((!line_event_input)[*4] |-> !event_rc_timing_oe)
        else $error("timing node held after trigger low");
    event_flag_a: assert property (s_node_low |-> !line_event_detected)
        else $error("line event not flagged");
    int_assert_a: assert property (
        (!line_event_detected || !word_ready_n || alert_tone_qualified) |-> ##[0:1] interrupt_oe)
        else $error("interrupt not asserted");
    int_release_a: assert property (s_int_idle |-> !interrupt_oe)
        else $error("interrupt held with all sources idle");
    carrier_low_a: assert property (
        (carrier_in && !power_down_request)[*4] |-> !carrier_present_n)
        else $error("carrier output not low");
    ready_after_pulse_a: assert property (
        $fell(word_ready_n) && !interface_mode |-> !serial_data_clock_out)
        else $error("word ready during clock pulse");
    clk_data_stable_a: assert property ($rose(serial_data_clock_out) |-> $stable(serial_data))
        else $error("data moved at clock rise");
    demod_gate_a: assert property ($fell(word_ready_n) |->
        $past(demod_enable, 3) || $past(demod_enable, 4) || $past(demod_enable, 5))
        else $error("word produced with demodulator off");
endmodule // cidrx_ctrl_asserts

bind cidrx_ctrl cidrx_ctrl_asserts chk_u (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .interface_mode(interface_mode), .power_down_request(power_down_request),
    .demod_enable(demod_enable), .carrier_in(carrier_in), .line_event_input(line_event_input),
    .event_rc_timing_in(event_rc_timing_in), .event_rc_timing_oe(event_rc_timing_oe),
    .line_event_detected(line_event_detected), .serial_data_clock_out(serial_data_clock_out),
    .serial_data_clock_oe(serial_data_clock_oe), .serial_data(serial_data),
    .word_ready_n(word_ready_n), .carrier_present_n(carrier_present_n),
    .alert_tone_qualified(alert_tone_qualified), .interrupt_oe(interrupt_oe));

/* File: cidrx_host_model.sv */
// host microcontroller model pulling one word in interface mode 1
`timescale 1ns/1ps
module cidrx_host_model (
    input  wire logic       go,
    input  wire logic       serial_data,
    output logic            host_clk,
    output logic [7:0]      got,
    output logic            done
);
    initial begin
        host_clk = 1'b0;
        got = 8'h00;
        done = 1'b0;
    end
    always @(posedge go) begin
        done = 1'b0;
        #7;
        repeat (8) begin
            #160 host_clk = 1'b1;
            #160 host_clk = 1'b0;
            got = {serial_data, got[7:1]};
        end
        done = 1'b1;
    end
endmodule // cidrx_host_model

/* File: cidrx_ctrl_bench.sv */
// self-checking bench for the caller-identity receiver control block
`timescale 1ns/1ps
module cidrx_ctrl_bench;
    localparam int BITC = 16;
    logic        ref_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, rdata;
    logic        interface_mode = 0, power_down_request = 0, demod_enable = 1;
    logic        fsk_bit_in = 1, carrier_in = 0, alert_tone_in = 0, line_event_input = 0;
    logic        go = 0, rerr;
    logic [7:0]  cap = 0, got;
    wire  [31:0] prdata;
    wire         pready, pslverr, irq, rc_oe, rc_out, line_event_detected, sclk_out, sclk_oe;
    wire         serial_data, word_ready_n, carrier_present_n, alert_tone_qualified;
    wire         int_out, interrupt_oe, host_clk, done;
    int          num_errors = 0, samples_checked = 0, npulse = 0, nword = 0, cyc = 0;
    // pull-up on the timing node, charge delay abstracted
    wire rc_node = rc_oe ? 1'b0 : 1'b1;
    wire serial_data_clock = sclk_oe ? sclk_out : host_clk;

    cidrx_ctrl #(.BIT_CYCLES(16'h0010)) dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .interface_mode(interface_mode), .power_down_request(power_down_request),
        .demod_enable(demod_enable), .fsk_bit_in(fsk_bit_in), .carrier_in(carrier_in),
        .alert_tone_in(alert_tone_in), .line_event_input(line_event_input),
        .event_rc_timing_in(rc_node), .event_rc_timing_out(rc_out), .event_rc_timing_oe(rc_oe),
        .line_event_detected(line_event_detected), .serial_data_clock_in(serial_data_clock),
        .serial_data_clock_out(sclk_out), .serial_data_clock_oe(sclk_oe),
        .serial_data(serial_data), .word_ready_n(word_ready_n),
        .carrier_present_n(carrier_present_n), .alert_tone_qualified(alert_tone_qualified),
        .interrupt_out(int_out), .interrupt_oe(interrupt_oe));
    cidrx_host_model host_u (.go(go), .serial_data(serial_data), .host_clk(host_clk),
        .got(got), .done(done));

    always #20 ref_clk = ~ref_clk;
    always @(posedge sclk_out) begin
        cap <= {serial_data, cap[7:1]};
        npulse++;
    end
    always @(negedge word_ready_n) nword++;
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            wrap_up;
        end
    end

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task cyc_n(input int k);
        repeat (k) @(posedge ref_clk);
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    task send(input logic [7:0] b);
        fsk_bit_in <= 1'b0;
        cyc_n(BITC);
        for (int i = 0; i < 8; i++) begin
            fsk_bit_in <= b[i];
            cyc_n(BITC);
        end
        fsk_bit_in <= 1'b1;
        cyc_n(2 * BITC);
    endtask
    task host_pull;
        go <= 1'b1;
        cyc_n(1);
        while (done !== 1'b1) @(posedge ref_clk);
        go <= 1'b0;
        cyc_n(4);
    endtask

    task t_regs;
        apb(1'b0, 12'h000, 32'h0);
        chk(rdata, 32'h1);
        apb(1'b1, 12'h008, 32'h1F);
        apb(1'b0, 12'h008, 32'h0);
        chk(rdata, 32'h1F);
        apb(1'b0, 12'h020, 32'h0);
        chk(rerr, 1'b1);
        apb(1'b1, 12'h008, 32'h0);
        $display("regs done");
    endtask
    task t_pdown;
        power_down_request <= 1'b1;
        carrier_in <= 1'b1;
        line_event_input <= 1'b1;
        cyc_n(8);
        chk(sclk_oe, 1'b0);
        chk(carrier_present_n, 1'b1);
        chk(line_event_detected, 1'b0);
        chk(interrupt_oe, 1'b1);
        chk(int_out, 1'b0);
        chk(rc_oe, 1'b1);
        chk(rc_out, 1'b0);
        line_event_input <= 1'b0;
        cyc_n(8);
        chk(line_event_detected, 1'b1);
        power_down_request <= 1'b0;
        cyc_n(5);
        chk(carrier_present_n, 1'b0);
        carrier_in <= 1'b0;
        alert_tone_in <= 1'b1;
        cyc_n(5);
        chk(alert_tone_qualified, 1'b1);
        chk(interrupt_oe, 1'b1);
        alert_tone_in <= 1'b0;
        cyc_n(5);
        chk(interrupt_oe, 1'b0);
        apb(1'b0, 12'h004, 32'h0);
        chk(rdata, 32'h16);
        $display("power-down done");
    endtask
    task t_mode0;
        apb(1'b1, 12'h00C, 32'h1F);
        apb(1'b1, 12'h008, 32'h1);
        npulse = 0;
        nword = 0;
        send(8'hA5);
        chk(cap, 8'hA5);
        chk(npulse, 8);
        chk(nword, 1);
        chk(irq, 1'b1);
        apb(1'b1, 12'h008, 32'h0);
        chk(irq, 1'b0);
        apb(1'b1, 12'h008, 32'h1);
        apb(1'b0, 12'h010, 32'h0);
        chk(rdata[15:8], 8'hA5);
        apb(1'b1, 12'h00C, 32'h1);
        chk(irq, 1'b0);
        $display("mode 0 done");
    endtask
    task t_mode1;
        interface_mode <= 1'b1;
        cyc_n(4);
        chk(sclk_oe, 1'b0);
        send(8'h3C);
        chk(word_ready_n, 1'b0);
        host_pull;
        chk(got, 8'h3C);
        chk(word_ready_n, 1'b1);
        send(8'h99);
        send(8'h66);
        apb(1'b0, 12'h004, 32'h0);
        chk(rdata, 32'h9);
        host_pull;
        chk(got, 8'h66);
        chk(word_ready_n, 1'b1);
        interface_mode <= 1'b0;
        cyc_n(4);
        $display("mode 1 done");
    endtask
    task t_gate;
        nword = 0;
        demod_enable <= 1'b0;
        cyc_n(4);
        send(8'h5A);
        chk(nword, 0);
        demod_enable <= 1'b1;
        apb(1'b1, 12'h000, 32'h0);
        send(8'h5A);
        chk(nword, 0);
        apb(1'b1, 12'h000, 32'h1);
        send(8'h5A);
        chk(nword, 1);
        chk(cap, 8'h5A);
        $display("gate done");
    endtask
    task wrap_up;
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        cyc_n(4);
        sys_rst <= 1'b0;
        cyc_n(3);
        t_regs;
        t_pdown;
        t_mode0;
        t_mode1;
        t_gate;
        wrap_up;
    end
endmodule // cidrx_ctrl_bench
